// ==== src/rx_framer_channel_control.sv ====
// Purpose: receive framer channel controls, register bank and data substitution
// Assumes: channel words and strobes synchronous to clk; e1Mode static in use
// Notes:   read data is registered, one cycle after the read strobe
//
// Overview of operation
// - remote alarm select picks all-channel bit-2 zeros or frame-12 S-bit one.
// - enabled Sa4..Sa8 changes in E1 set latched status seven bit 0.
// - address 014h holds Sa masks in E1, alarm select register in T1.
// - host sets code detector reset; device clears it when reset completes, bounded.
// - new filter settings reach the detector only after its reset completes.
// - cleared flag after 16, 32, 48 or 64 bits without valid code.
// - valid code after 1, 3, 5 or 7 identical error-free codes.
// - detector never integrates and disintegrates at the same time.
// - idle code registers hold 8-bit codes, bit 0 least significant, sent last.
// - idle codes at 020h for channel 1 up to 03Fh for channel 32.
// - idle codes 1-24 used only in T1, 25-32 only in E1.
// - forced channels carry a one in bit 0 on serial out in T1 signaling frames; signaling out stays true.
// - per-channel forcing acts only with signaling control bit 4 set.
// - three force registers, bit 0 of the first is channel 1.
// - milliwatt enabled channels get milliwatt code, others pass unchanged.
// - in T1, signaling control bit 4 lets the force registers set robbed-bit signaling to one.
`timescale 1ns/10ps
`default_nettype none
module rx_framer_channel_control
    import rfcc_pkg::*;
#(
    parameter logic [63:0] MW_CODE = 64'h1e0b0b1e9e8b8b9e
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       e1Mode,
    input  wire logic [7:0] busAddr,
    input  wire logic       busWr,
    input  wire logic       busRd,
    input  wire logic [7:0] busWdata,
    output logic [7:0]      busRdata,
    input  wire rfcc_chan_s chanIn,
    input  wire logic       frameStart,
    input  wire logic [3:0] frameNum,
    input  wire logic       sBit,
    input  wire logic       saStrobe,
    input  wire logic [4:0] saBits,
    input  wire rfcc_pat_s  bocPat,
    input  wire logic       bocBitStrobe,
    output rfcc_chan_s      rx_serial_out,
    output logic            rx_signaling_out,
    output logic [7:0]      idleCode,
    output logic            remoteAlarm,
    output logic            receive_latched_status_seven,
    output logic            codeValid,
    output logic [5:0]      codeOut,
    output logic            code_cleared_flag
);
    typedef struct packed {
        logic                 force_signaling_ones_en;
        logic                 remote_alarm_select;
        logic [SA_MASK_W-1:0] saMask;
        logic                 code_detector_reset_req;
        logic [1:0]           code_clear_filter;
        logic [1:0]           code_valid_filter;
        logic [NUM_CH-1:0][7:0] idle;
        logic [2:0][7:0]      forceOnes;
        logic [2:0][7:0]      mwEn;
        logic                 lstatSa;
        logic [SA_MASK_W-1:0] saPrev;
        logic                 saSeen;
        logic                 allZero;
        logic                 remAlarm;
        logic [2:0]           mwPhase;
        logic [7:0]           rdata;
        rfcc_chan_s           out;
        logic                 sigOut;
        logic [7:0]           idleOut;
    } rfcc_state_s;

    rfcc_state_s s;
    rfcc_state_s next_s;
    logic        bocDone;
    logic        inT1Range;
    logic        chForce;
    logic        chMw;
    logic [4:0]  idleIdx;
    logic [1:0]  grpIdx;
    logic [7:0]  rd;
    logic [7:0]  chData;
    logic        saChange;
    logic        idleLegal;

    rfcc_boc_detect u_boc (
        .clk             (clk),
        .rst             (rst),
        .resetReq        (s.code_detector_reset_req),
        .validSel        (s.code_valid_filter),
        .clearSel        (s.code_clear_filter),
        .pat             (bocPat),
        .bitStrobe       (bocBitStrobe),
        .resetDone       (bocDone),
        .codeValid       (codeValid),
        .codeOut         (codeOut),
        .codeClearedFlag (code_cleared_flag)
    );

    always_comb begin
        next_s = s;
        idleIdx = busAddr[4:0];
        grpIdx = 2'd0;
        rd = REG_RESET;
        inT1Range = (chanIn.idx <= T1_LAST_IDX);
        chForce = inT1Range && s.forceOnes[chanIn.idx[4:3]][chanIn.idx[2:0]];
        chMw = inT1Range && s.mwEn[chanIn.idx[4:3]][chanIn.idx[2:0]];
        chData = chanIn.data;
        saChange = |((saBits ^ s.saPrev) & s.saMask);
        // codes outside the current line mode are not used
        idleLegal = e1Mode ? !inT1Range : inT1Range;

        // register writes
        if (busWr) begin
            if (busAddr == ADDR_SIG_CTRL) begin
                next_s.force_signaling_ones_en = busWdata[SIG_FORCE_BIT];
            end
            // shared address decoded by line mode
            if (busAddr == ADDR_MODE_SHARE) begin
                if (e1Mode) begin
                    next_s.saMask = busWdata[SA_MASK_W-1:0];
                end else begin
                    next_s.remote_alarm_select = busWdata[RAS_BIT];
                end
            end
            // control register exists in T1 only
            if (busAddr == ADDR_BOC_CTRL && !e1Mode) begin
                next_s.code_detector_reset_req = busWdata[BOC_RST_BIT];
                next_s.code_clear_filter = busWdata[BOC_CLR_LSB +: 2];
                next_s.code_valid_filter = busWdata[BOC_VAL_LSB +: 2];
            end
            if (busAddr >= ADDR_IDLE_FIRST && busAddr <= ADDR_IDLE_LAST) begin
                next_s.idle[idleIdx] = busWdata;
            end
            // three force registers of eight channels
            if (busAddr >= ADDR_FORCE_1 && busAddr <= ADDR_FORCE_3) begin
                grpIdx = 2'(busAddr - ADDR_FORCE_1);
                next_s.forceOnes[grpIdx] = busWdata;
            end
            // milliwatt enables share the same layout
            if (busAddr >= ADDR_MW_1 && busAddr <= ADDR_MW_3) begin
                grpIdx = 2'(busAddr - ADDR_MW_1);
                next_s.mwEn[grpIdx] = busWdata;
            end
            if (busAddr == ADDR_LSTAT7 && busWdata[LSTAT_SA_BIT]) begin
                next_s.lstatSa = 1'b0;
            end
        end

        if (bocDone) begin
            next_s.code_detector_reset_req = 1'b0;
        end

        // masked Sa change sets latched status, set wins over clear
        if (saStrobe) begin
            if (e1Mode && s.saSeen && saChange) begin
                next_s.lstatSa = 1'b1;
            end
            next_s.saPrev = saBits;
            next_s.saSeen = 1'b1;
        end

        // remote alarm detection per selected criterion
        if (!e1Mode && chanIn.strobe && chanIn.data[CH_BIT2_POS]) begin
            next_s.allZero = 1'b0;
        end
        if (frameStart) begin
            next_s.allZero = 1'b1;
            next_s.mwPhase = s.mwPhase + 3'd1;
            if (!s.remote_alarm_select) begin
                next_s.remAlarm = s.allZero;
            end else if (frameNum == RAI_FRAME) begin
                next_s.remAlarm = sBit;
            end
        end

        // milliwatt substitution; a clear bit passes data unchanged
        if (chMw) begin
            chData = MW_CODE[(7 - int'(s.mwPhase)) * 8 +: 8];
        end
        // forcing gated by the signaling control bit
        // robbed bit forced to one in T1 signaling frames
        if (!e1Mode && s.force_signaling_ones_en && chForce && chanIn.sigFrame) begin
            chData[0] = 1'b1;
        end
        next_s.out.strobe = chanIn.strobe;
        if (chanIn.strobe) begin
            next_s.out.idx = chanIn.idx;
            next_s.out.sigFrame = chanIn.sigFrame;
            next_s.out.data = chData;
            // signaling output keeps the received bit
            next_s.sigOut = chanIn.sigFrame && chanIn.data[0];
            // code presented whole, bit 0 is its last serial bit
            next_s.idleOut = idleLegal ? s.idle[chanIn.idx] : REG_RESET;
        end

        if (busAddr == ADDR_SIG_CTRL) begin
            rd[SIG_FORCE_BIT] = s.force_signaling_ones_en;
        end else if (busAddr == ADDR_MODE_SHARE) begin
            if (e1Mode) begin
                rd[SA_MASK_W-1:0] = s.saMask;
            end else begin
                rd[RAS_BIT] = s.remote_alarm_select;
            end
        end else if (busAddr == ADDR_BOC_CTRL && !e1Mode) begin
            rd[BOC_RST_BIT] = s.code_detector_reset_req;
            rd[BOC_CLR_LSB +: 2] = s.code_clear_filter;
            rd[BOC_VAL_LSB +: 2] = s.code_valid_filter;
        end else if (busAddr >= ADDR_IDLE_FIRST && busAddr <= ADDR_IDLE_LAST) begin
            rd = s.idle[idleIdx];
        end else if (busAddr >= ADDR_FORCE_1 && busAddr <= ADDR_FORCE_3) begin
            rd = s.forceOnes[2'(busAddr - ADDR_FORCE_1)];
        end else if (busAddr >= ADDR_MW_1 && busAddr <= ADDR_MW_3) begin
            rd = s.mwEn[2'(busAddr - ADDR_MW_1)];
        end else if (busAddr == ADDR_LSTAT7) begin
            rd[LSTAT_SA_BIT] = s.lstatSa;
        end
        if (busRd) begin
            next_s.rdata = rd;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busRdata = s.rdata;
    assign rx_serial_out = s.out;
    assign rx_signaling_out = s.sigOut;
    assign idleCode = s.idleOut;
    assign remoteAlarm = s.remAlarm;
    assign receive_latched_status_seven = s.lstatSa;

    chk_rst_bit_clears: assert property (@(posedge clk) disable iff (rst)
        $rose(s.code_detector_reset_req) |-> ##[1:8] !s.code_detector_reset_req)
        else $error("detector reset request never cleared");
    chk_sa_change_set: assert property (@(posedge clk) disable iff (rst)
        (saStrobe && e1Mode && s.saSeen && saChange) |=> receive_latched_status_seven)
        else $error("enabled Sa change did not latch status");
    chk_sa_mask_t1: assert property (@(posedge clk) disable iff (rst)
        (busWr && busAddr == ADDR_MODE_SHARE && !e1Mode) |=> $stable(s.saMask))
        else $error("Sa mask written in T1 mode");
    chk_force_ones_out: assert property (@(posedge clk) disable iff (rst)
        (chanIn.strobe && !e1Mode && s.force_signaling_ones_en && chForce && chanIn.sigFrame)
        |=> rx_serial_out.data[0] && rx_signaling_out == $past(chanIn.data[0]))
        else $error("forced channel not ones or signaling output altered");
    chk_force_gated: assert property (@(posedge clk) disable iff (rst)
        (chanIn.strobe && !s.force_signaling_ones_en && !chMw)
        |=> rx_serial_out.data == $past(chanIn.data))
        else $error("channel data changed without enable");
    chk_mw_subst: assert property (@(posedge clk) disable iff (rst)
        (chanIn.strobe && chMw && !chForce)
        |=> rx_serial_out.data == MW_CODE[(7 - int'($past(s.mwPhase))) * 8 +: 8])
        else $error("milliwatt code not substituted");
    chk_ras_frame12: assert property (@(posedge clk) disable iff (rst)
        (frameStart && s.remote_alarm_select && frameNum == RAI_FRAME)
        |=> remoteAlarm == $past(sBit))
        else $error("frame 12 S-bit alarm not followed");
    chk_ras_zeros: assert property (@(posedge clk) disable iff (rst)
        (frameStart && !s.remote_alarm_select) |=> remoteAlarm == $past(s.allZero))
        else $error("bit-2 zeros alarm not followed");
    chk_idle_mode: assert property (@(posedge clk) disable iff (rst)
        (chanIn.strobe && e1Mode && inT1Range) |=> idleCode == REG_RESET)
        else $error("T1 idle code used in E1 mode");
    chk_reset_zero: assert property (@(posedge clk)
        rst |=> busRdata == REG_RESET && !receive_latched_status_seven)
        else $error("register not zero after reset");
endmodule
`default_nettype wire

// ==== src/rfcc_pkg.sv ====
// Purpose: shared constants and carriers of the receive framer channel control
// Assumes: 8-bit host port, byte addressed, 25 MHz clock
// Notes:   offsets, bit positions, reset values and counts live here only
`default_nettype none
package rfcc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SIG_CTRL   = 8'h13;
    localparam logic [7:0] ADDR_MODE_SHARE = 8'h14;
    localparam logic [7:0] ADDR_BOC_CTRL   = 8'h15;
    localparam logic [7:0] ADDR_IDLE_FIRST = 8'h20;
    localparam logic [7:0] ADDR_IDLE_LAST  = 8'h3f;
    localparam logic [7:0] ADDR_FORCE_1    = 8'hc0;
    localparam logic [7:0] ADDR_FORCE_3    = 8'hc2;
    localparam logic [7:0] ADDR_MW_1       = 8'hc3;
    localparam logic [7:0] ADDR_MW_3       = 8'hc5;
    localparam logic [7:0] ADDR_LSTAT7     = 8'hc6;
    localparam logic [7:0] REG_RESET       = 8'h00;
    // field positions
    localparam int SIG_FORCE_BIT = 4;
    localparam int RAS_BIT       = 0;
    localparam int SA_MASK_W     = 5;
    localparam int BOC_RST_BIT   = 7;
    localparam int BOC_CLR_LSB   = 4;
    localparam int BOC_VAL_LSB   = 1;
    localparam int LSTAT_SA_BIT  = 0;
    localparam int CH_BIT2_POS   = 6;
    // channels
    localparam int NUM_CH = 32;
    localparam int T1_CH  = 24;
    localparam logic [4:0] T1_LAST_IDX = 5'd23;
    localparam logic [3:0] RAI_FRAME   = 4'd12;
    // code detector timing
    localparam int CLK_NS          = 40;
    localparam int BOC_RST_MAX_NS  = 250000;
    localparam int BOC_RST_MAX_CYC = BOC_RST_MAX_NS / CLK_NS;
    localparam logic [2:0] BOC_RST_CYC = 3'd4;
    localparam logic [6:0] BOC_CLR_STEP = 7'd16;
    localparam logic [2:0] BOC_VAL_N1 = 3'd3;
    localparam logic [2:0] BOC_VAL_N2 = 3'd5;
    localparam logic [2:0] BOC_VAL_N3 = 3'd7;

    typedef enum logic [3:0] {
        BOC_IDLE  = 4'b0001,
        BOC_RESET = 4'b0010,
        BOC_INTEG = 4'b0100,
        BOC_DISIN = 4'b1000
    } rfcc_boc_e;

    typedef struct packed {
        logic       strobe;
        logic [4:0] idx;
        logic [7:0] data;
        logic       sigFrame;
    } rfcc_chan_s;

    typedef struct packed {
        logic       strobe;
        logic [5:0] code;
        logic       ok;
    } rfcc_pat_s;
endpackage
`default_nettype wire

// ==== src/rfcc_boc_detect.sv ====
// Purpose: bit oriented code detector with validity and clear filters
// Assumes: pattern and message bit strobes are one-cycle pulses
// Notes:   filter selections are sampled only during the detector reset
`timescale 1ns/10ps
`default_nettype none
module rfcc_boc_detect
    import rfcc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       resetReq,
    input  wire logic [1:0] validSel,
    input  wire logic [1:0] clearSel,
    input  wire rfcc_pat_s  pat,
    input  wire logic       bitStrobe,
    output logic            resetDone,
    output logic            codeValid,
    output logic [5:0]      codeOut,
    output logic            codeClearedFlag
);
    typedef struct packed {
        rfcc_boc_e  st;
        logic [6:0] cnt;
        logic [2:0] rstCnt;
        logic [1:0] vSel;
        logic [1:0] cSel;
        logic [5:0] lastCode;
        logic [5:0] code;
        logic       done;
        logic       cleared;
    } rfcc_det_s;

    rfcc_det_s s;
    rfcc_det_s next_s;
    logic [2:0] needValid;
    logic [6:0] needClear;

    always_comb begin
        case (s.vSel)
            2'd0:    needValid = 3'd1;
            2'd1:    needValid = BOC_VAL_N1;
            2'd2:    needValid = BOC_VAL_N2;
            default: needValid = BOC_VAL_N3;
        endcase
        needClear = BOC_CLR_STEP * ({5'd0, s.cSel} + 7'd1);
    end

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.cleared = 1'b0;
        case (s.st)
            BOC_RESET: begin
                next_s.vSel = validSel;
                next_s.cSel = clearSel;
                next_s.cnt = 7'd0;
                next_s.rstCnt = s.rstCnt + 3'd1;
                if (s.rstCnt == BOC_RST_CYC - 3'd1) begin
                    next_s.done = 1'b1;
                    next_s.st = BOC_INTEG;
                end
            end
            BOC_INTEG: begin
                if (pat.strobe) begin
                    next_s.lastCode = pat.code;
                    if (!pat.ok) begin
                        next_s.cnt = 7'd0;
                    end else if (s.cnt == 7'd0 || pat.code == s.lastCode) begin
                        next_s.cnt = s.cnt + 7'd1;
                    end else begin
                        next_s.cnt = 7'd1;
                    end
                    if (pat.ok && next_s.cnt >= {4'd0, needValid}) begin
                        next_s.code = pat.code;
                        next_s.cnt = 7'd0;
                        next_s.st = BOC_DISIN;
                    end
                end
            end
            // disintegration only while valid, never with integration
            BOC_DISIN: begin
                if (pat.strobe && pat.ok && pat.code == s.code) begin
                    next_s.cnt = 7'd0;
                end else if (bitStrobe) begin
                    next_s.cnt = s.cnt + 7'd1;
                    if (s.cnt + 7'd1 == needClear) begin
                        next_s.cnt = 7'd0;
                        next_s.cleared = 1'b1;
                        next_s.st = BOC_INTEG;
                    end
                end
            end
            default: begin
                next_s.st = BOC_INTEG;
            end
        endcase
        // done blocks a retrigger while the request bit is still being cleared
        if (resetReq && !s.done && s.st != BOC_RESET) begin
            next_s.st = BOC_RESET;
            next_s.rstCnt = 3'd0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{st: BOC_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign resetDone = s.done;
    assign codeValid = (s.st == BOC_DISIN);
    assign codeOut = s.code;
    assign codeClearedFlag = s.cleared;

    chk_boc_reset_bound: assert property (@(posedge clk) disable iff (rst)
        (s.st == BOC_RESET && $past(s.st) != BOC_RESET) |-> ##[3:4] resetDone)
        else $error("code detector reset did not finish in time");
    chk_boc_no_overlap: assert property (@(posedge clk) disable iff (rst)
        (s.st == BOC_INTEG) |-> !codeClearedFlag || $past(s.st) == BOC_DISIN)
        else $error("clear reported while integrating");
endmodule
`default_nettype wire

// ==== src/_unused_placeholder_removed.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== verif/rfcc_stream_model.sv ====
// Purpose: behavioural source of the recovered receive frame stream
// Assumes: changes after the falling edge; strobes last one cycle
// Notes:   released word data shows its inverse so stale values never match
`timescale 1ns/10ps
`default_nettype none
module rfcc_stream_model
    import rfcc_pkg::*;
(
    input  wire logic  clk,
    output rfcc_chan_s chanIn,
    output logic       frameStart,
    output logic [3:0] frameNum,
    output logic       sBit,
    output logic       saStrobe,
    output logic [4:0] saBits,
    output rfcc_pat_s  bocPat,
    output logic       bocBitStrobe
);
    initial begin
        chanIn = '0;
        bocPat = '0;
        {frameStart, frameNum, sBit, saStrobe, saBits, bocBitStrobe} = '0;
    end
    task automatic word(input logic [4:0] idx, input logic [7:0] d, input logic sf);
        @(negedge clk);
        chanIn = '{1'b1, idx, d, sf};
        @(negedge clk);
        chanIn = '{1'b0, idx, ~d, sf};
    endtask
    task automatic frame(input logic [3:0] n, input logic s);
        @(negedge clk);
        {frameStart, frameNum, sBit} = {1'b1, n, s};
        @(negedge clk);
        {frameStart, sBit} = {1'b0, ~s};
    endtask
    task automatic sa(input logic [4:0] b);
        @(negedge clk);
        {saStrobe, saBits} = {1'b1, b};
        @(negedge clk);
        saStrobe = 1'b0;
    endtask
    task automatic pat(input logic [5:0] c);
        @(negedge clk);
        bocPat = '{1'b1, c, 1'b1};
        @(negedge clk);
        bocPat = '{1'b0, ~c, 1'b0};
    endtask
    task automatic bitp();
        @(negedge clk);
        bocBitStrobe = 1'b1;
        @(negedge clk);
        bocBitStrobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/test_rx_framer_channel_control.sv ====
// Purpose: self-checking bench of the receive framer channel control
// Assumes: inputs change at the falling edge; reads sampled one cycle later
// Notes:   detector runs with the default short reset, no long counts
`timescale 1ns/10ps
`default_nettype none
module test_rx_framer_channel_control;
    import rfcc_pkg::*;
    localparam logic [63:0] MW = 64'h1e0b0b1e9e8b8b9e;
    logic       clk = 1'b0, rst = 1'b1, e1Mode = 1'b0, busWr = 1'b0, busRd = 1'b0;
    logic [7:0] busAddr = 8'h00, busWdata = 8'h00, busRdata, rd, idleCode;
    rfcc_chan_s chanIn, serOut;
    rfcc_pat_s  bocPat;
    logic       frameStart, sBit, saStrobe, bocBit, sigOut, alarm, saStat, cValid, clrFlag;
    logic [3:0] frameNum;
    logic [4:0] saBits;
    logic [5:0] codeOut;
    logic       sawClr = 1'b0;
    int         n_errors = 0;
    int         samples_checked = 0;
    always #20 clk = ~clk;
    always @(negedge clk) if (clrFlag === 1'b1) sawClr <= 1'b1;
    rfcc_stream_model u_src (.clk(clk), .chanIn(chanIn), .frameStart(frameStart),
        .frameNum(frameNum), .sBit(sBit), .saStrobe(saStrobe), .saBits(saBits),
        .bocPat(bocPat), .bocBitStrobe(bocBit));
    rx_framer_channel_control #(.MW_CODE(MW)) u_dut (.clk(clk), .rst(rst), .e1Mode(e1Mode),
        .busAddr(busAddr), .busWr(busWr), .busRd(busRd), .busWdata(busWdata),
        .busRdata(busRdata), .chanIn(chanIn), .frameStart(frameStart), .frameNum(frameNum),
        .sBit(sBit), .saStrobe(saStrobe), .saBits(saBits), .bocPat(bocPat),
        .bocBitStrobe(bocBit), .rx_serial_out(serOut), .rx_signaling_out(sigOut),
        .idleCode(idleCode), .remoteAlarm(alarm), .receive_latched_status_seven(saStat),
        .codeValid(cValid), .codeOut(codeOut), .code_cleared_flag(clrFlag));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {busAddr, busWdata, busWr} = {a, d, 1'b1};
        @(negedge clk);
        busWr = 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {busAddr, busRd} = {a, 1'b1};
        @(negedge clk);
        busRd = 1'b0;
        d = busRdata;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic test_regs();
        logic [7:0] a [6] = '{8'h13, 8'h14, 8'h15, 8'h20, 8'hc0, 8'hc5};
        foreach (a[i]) begin
            rdr(a[i], rd);
            chk("reset value", 8'h00, rd);
        end
        wr(8'h90, 8'hff);
        rdr(8'h90, rd);
        chk("unmapped", 8'h00, rd);
        wr(8'h3f, 8'ha5);
        rdr(8'h3f, rd);
        chk("idle 32 readback", 8'ha5, rd);
        $display("registers done");
    endtask
    task automatic test_subst();
        wr(8'hc0, 8'h01);
        u_src.word(5'd0, 8'h10, 1'b1);
        chk("unforced", 8'h10, serOut.data);
        wr(8'h13, 8'h10);
        u_src.word(5'd0, 8'h10, 1'b1);
        chk("forced ch1", 8'h11, serOut.data);
        chk("true signaling", 8'h00, sigOut);
        u_src.word(5'd1, 8'h10, 1'b1);
        chk("ch2 unforced", 8'h10, serOut.data);
        wr(8'hc2, 8'h80);
        u_src.word(5'd23, 8'h20, 1'b1);
        chk("forced ch24", 8'h21, serOut.data);
        wr(8'h13, 8'h00);
        wr(8'hc0, 8'h00);
        wr(8'hc2, 8'h00);
        wr(8'hc3, 8'h01);
        u_src.word(5'd0, 8'h55, 1'b0);
        chk("milliwatt ch1", MW[63:56], serOut.data);
        u_src.word(5'd1, 8'h55, 1'b0);
        chk("ch2 passes", 8'h55, serOut.data);
        u_src.frame(4'd1, 1'b0);
        u_src.word(5'd0, 8'h55, 1'b0);
        chk("milliwatt phase 1", MW[55:48], serOut.data);
        wr(8'hc3, 8'h00);
        $display("substitution done");
    endtask
    task automatic test_alarm();
        u_src.frame(4'd1, 1'b0);
        u_src.word(5'd3, 8'h40, 1'b0);
        u_src.frame(4'd2, 1'b0);
        chk("bit 2 seen", 8'h00, alarm);
        u_src.frame(4'd3, 1'b0);
        chk("bit 2 zeros", 8'h01, alarm);
        wr(8'h14, 8'h01);
        u_src.frame(4'd12, 1'b0);
        chk("frame 12 zero", 8'h00, alarm);
        u_src.frame(4'd12, 1'b1);
        chk("frame 12 one", 8'h01, alarm);
        rdr(8'h14, rd);
        chk("T1 decode 014", 8'h01, rd);
        $display("alarm done");
    endtask
    task automatic test_boc();
        wr(8'h15, 8'h82);
        rd = 8'h80;
        for (int i = 0; i < 20 && rd[7] !== 1'b0; i++) rdr(8'h15, rd);
        chk("reset acknowledged", 8'h02, rd);
        wr(8'h15, 8'h00);
        repeat (2) u_src.pat(6'h2a);
        repeat (2) @(negedge clk);
        chk("valid after 2", 8'h00, cValid);
        u_src.pat(6'h2a);
        repeat (2) @(negedge clk);
        chk("valid after 3", 8'h01, cValid);
        chk("code", 8'h2a, codeOut);
        repeat (15) u_src.bitp();
        repeat (3) @(negedge clk);
        chk("early clear", 8'h00, sawClr);
        u_src.bitp();
        repeat (3) @(negedge clk);
        chk("clear at 16", 8'h01, sawClr);
        chk("valid dropped", 8'h00, cValid);
        $display("code detector done");
    endtask
    task automatic test_e1();
        wr(8'h37, 8'h5c);
        wr(8'h38, 8'hc3);
        u_src.word(5'd23, 8'h00, 1'b0);
        chk("idle ch24 T1", 8'h5c, idleCode);
        u_src.word(5'd24, 8'h00, 1'b0);
        chk("idle ch25 T1", 8'h00, idleCode);
        e1Mode = 1'b1;
        u_src.word(5'd24, 8'h00, 1'b0);
        chk("idle ch25 E1", 8'hc3, idleCode);
        wr(8'h14, 8'h10);
        u_src.sa(5'h00);
        u_src.sa(5'h01);
        @(negedge clk);
        chk("masked change", 8'h00, saStat);
        u_src.sa(5'h11);
        @(negedge clk);
        chk("enabled change", 8'h01, saStat);
        rdr(8'h14, rd);
        chk("E1 decode 014", 8'h10, rd);
        wr(8'hc6, 8'h01);
        chk("status cleared", 8'h00, saStat);
        $display("E1 done");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        test_regs();
        test_subst();
        test_alarm();
        test_boc();
        test_e1();
        conclude();
    end
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
